// File: design/itf_defs.svh
// register offsets, field positions and reset values of the task-file bank
`ifndef ITF_DEFS_SVH
`define ITF_DEFS_SVH
`define ITF_OFF_CYL_HIGH 3'h5
`define ITF_OFF_DRIVE_HEAD 3'h6
`define ITF_OFF_STATUS 3'h7
`define ITF_DEV_BIT 4
`define ITF_BUSY_BIT 7
`define ITF_DATA_RESET 8'h00
`define ITF_STATUS_RESET 8'h80
`define ITF_FW_SEL_CYL_MASTER 3'h0
`define ITF_FW_SEL_CYL_SLAVE 3'h1
`define ITF_FW_SEL_DH_MASTER 3'h2
`define ITF_FW_SEL_DH_SLAVE 3'h3
`define ITF_FW_SEL_STATUS 3'h4
`endif

// File: design/itf_pkg.sv
// types shared by the task-file bank
package itf_pkg;
    typedef logic [7:0] itf_byte_t;
    typedef logic [2:0] itf_addr_t;
    typedef enum logic [1:0] {
        ITF_RD_NONE,
        ITF_RD_CYL,
        ITF_RD_DH,
        ITF_RD_STATUS
    } itf_rdsel_e;
endpackage

// File: design/itf_ctl_if.sv
// reset and soft-reset events passed to the status unit
`timescale 1ns/1ps
`default_nettype none
interface itf_ctl_if;
    import itf_pkg::*;
    logic func_reset;
    logic soft_reset_rise;
    logic cmd_write_master;
    logic status_read_master;
    logic fw_status_we;
    itf_byte_t fw_status_data;
    itf_byte_t status;
    logic irq_master;
    logic irq_set;
    modport top (output func_reset, soft_reset_rise, cmd_write_master, status_read_master,
        fw_status_we, fw_status_data, irq_set, input status, irq_master);
    modport unit (input func_reset, soft_reset_rise, cmd_write_master, status_read_master,
        fw_status_we, fw_status_data, irq_set, output status, irq_master);
endinterface
`default_nettype wire

// File: design/itf_status.sv
// master status register with busy set logic and drive-0 interrupt
`timescale 1ns/1ps
`default_nettype none
`include "itf_defs.svh"
module itf_status
    import itf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    itf_ctl_if.unit ctl
);
    itf_byte_t status_reg;
    itf_byte_t status_next;
    logic irq_reg;
    logic busy_set;

    assign busy_set = ctl.func_reset | ctl.soft_reset_rise | ctl.cmd_write_master;
    // firmware write first, hardware set overrides busy so a set is never lost
    always_comb begin
        status_next = status_reg;
        if (ctl.fw_status_we) begin
            status_next = ctl.fw_status_data;
        end
        if (busy_set) begin
            status_next[`ITF_BUSY_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= `ITF_STATUS_RESET;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= ctl.func_reset ? `ITF_STATUS_RESET : status_next;
            if (ctl.irq_set | ~ctl.status_read_master) begin
                irq_reg <= ctl.irq_set ? 1'b1 : irq_reg;
            end else begin
                irq_reg <= 1'b0;
            end
        end
    end

    assign ctl.status = status_reg;
    assign ctl.irq_master = irq_reg;
endmodule
`default_nettype wire

// File: design/itf_bank.sv
// emulated task-file bank: cylinder high, drive/head and master status
// Behaviour
// - host cylinder-high write loads input and both drive copies together
// - cylinder-high read returns drive-0 copy if select is 0, else drive-1
// - host drive/head write loads input and both drive copies together
// - drive/head read returns drive-0 copy if select is 0, else drive-1
// - drive/head bit 4 is the drive select steering host reads
// - drive select clears on soft-reset rising edge and function reset
// - drive/head copies take each host write along with the input; firmware can load one copy alone
// - status is host read-only; each host read with drive select 0 clears drive-0 interrupt unless irq_event sets it in that cycle
// - host write at status address goes to the command register
// - busy sets on master command write, soft reset, function reset
// - status bits 6..3 hold ready, fault, seek done, transfer request
// - status bits 2..0 hold fixed read, index mark, previous error
// - function reset returns data registers to 00h and status to 80h
// - soft-reset control bit forces emulated drive reset effects
`timescale 1ns/1ps
`default_nettype none
`include "itf_defs.svh"
module itf_bank
    import itf_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic d3_to_d0,
    input wire logic host_cs,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire logic soft_reset_bit,
    input wire logic fw_we,
    input wire logic [2:0] fw_sel,
    input wire logic [7:0] fw_wdata,
    input wire logic irq_event,
    output logic irq_master,
    output logic [7:0] command_out,
    output logic command_strobe,
    output logic [7:0] cyl_high_in,
    output logic [7:0] drive_head_in,
    output logic drive_select
);
    ////////////////////////////////////////////////////////////////
    logic rst_s1_reg;
    logic rst_n;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // three copies each of cylinder high and drive/head: the input one plus one for each drive
    itf_byte_t cyl_in_reg;
    itf_byte_t cyl_m_reg;
    itf_byte_t cyl_s_reg;
    itf_byte_t dh_in_reg;
    itf_byte_t dh_m_reg;
    itf_byte_t dh_s_reg;
    itf_byte_t cmd_reg;
    itf_byte_t rdata_reg;
    logic srst_prev_reg;
    logic cmd_stb_reg;
    logic dev_sel;
    itf_ctl_if ctl();

    function automatic logic hit(input itf_addr_t a, input itf_addr_t off);
        hit = (a == off);
    endfunction

    wire hw = host_cs & host_wr;
    wire hr = host_cs & host_rd;
    wire hw_cyl = hw & hit(host_addr, `ITF_OFF_CYL_HIGH);
    wire hw_dh = hw & hit(host_addr, `ITF_OFF_DRIVE_HEAD);
    wire hw_cmd = hw & hit(host_addr, `ITF_OFF_STATUS);
    wire hr_cyl = hr & hit(host_addr, `ITF_OFF_CYL_HIGH);
    wire hr_dh = hr & hit(host_addr, `ITF_OFF_DRIVE_HEAD);
    wire hr_st = hr & hit(host_addr, `ITF_OFF_STATUS);
    wire srst_rise = soft_reset_bit & ~srst_prev_reg;
    // firmware lanes, host write on the same copy wins
    wire fw_cm = fw_we & (fw_sel == `ITF_FW_SEL_CYL_MASTER) & ~hw_cyl;
    wire fw_cs = fw_we & (fw_sel == `ITF_FW_SEL_CYL_SLAVE) & ~hw_cyl;
    wire fw_dm = fw_we & (fw_sel == `ITF_FW_SEL_DH_MASTER) & ~hw_dh;
    wire fw_ds = fw_we & (fw_sel == `ITF_FW_SEL_DH_SLAVE) & ~hw_dh;
    wire fw_st = fw_we & (fw_sel == `ITF_FW_SEL_STATUS);

    // select taken from the input copy, the one the host last wrote
    assign dev_sel = dh_in_reg[`ITF_DEV_BIT];

    itf_rdsel_e rd_sel;
    assign rd_sel = hr_cyl ? ITF_RD_CYL : hr_dh ? ITF_RD_DH : hr_st ? ITF_RD_STATUS : ITF_RD_NONE;

    itf_byte_t rd_mux;
    always_comb begin
        case (rd_sel)
            ITF_RD_CYL: rd_mux = dev_sel ? cyl_s_reg : cyl_m_reg;
            ITF_RD_DH: rd_mux = dev_sel ? dh_s_reg : dh_m_reg;
            ITF_RD_STATUS: rd_mux = ctl.status;
            default: rd_mux = `ITF_DATA_RESET;
        endcase
    end

    assign ctl.func_reset = d3_to_d0;
    assign ctl.soft_reset_rise = srst_rise;
    assign ctl.cmd_write_master = hw_cmd & ~dev_sel;
    assign ctl.status_read_master = hr_st & ~dev_sel;
    assign ctl.fw_status_we = fw_st;
    assign ctl.fw_status_data = fw_wdata;
    assign ctl.irq_set = irq_event;

    itf_status u_status (
        .clk(clk),
        .rst_n(rst_n),
        .ctl(ctl)
    );

    ////////////////////////////////////////////////////////////////
    // clear on the select only: the other drive/head bits survive soft reset
    function automatic itf_byte_t clr_dev(input itf_byte_t v, input logic c);
        clr_dev = v;
        if (c) begin
            clr_dev[`ITF_DEV_BIT] = 1'b0;
        end
    endfunction

    // host byte first, then firmware; the select clear applies last of all
    itf_byte_t cyl_m_next;
    itf_byte_t cyl_s_next;
    itf_byte_t dh_in_next;
    itf_byte_t dh_m_next;
    itf_byte_t dh_s_next;
    assign cyl_m_next = hw_cyl ? host_wdata : fw_cm ? fw_wdata : cyl_m_reg;
    assign cyl_s_next = hw_cyl ? host_wdata : fw_cs ? fw_wdata : cyl_s_reg;
    assign dh_in_next = clr_dev(hw_dh ? host_wdata : dh_in_reg, srst_rise);
    assign dh_m_next = clr_dev(hw_dh ? host_wdata : fw_dm ? fw_wdata : dh_m_reg, srst_rise);
    assign dh_s_next = clr_dev(hw_dh ? host_wdata : fw_ds ? fw_wdata : dh_s_reg, srst_rise);

    // function reset is synchronous and outranks every host or firmware write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyl_in_reg <= `ITF_DATA_RESET;
            cyl_m_reg <= `ITF_DATA_RESET;
            cyl_s_reg <= `ITF_DATA_RESET;
        end else if (d3_to_d0) begin
            cyl_in_reg <= `ITF_DATA_RESET;
            cyl_m_reg <= `ITF_DATA_RESET;
            cyl_s_reg <= `ITF_DATA_RESET;
        end else begin
            cyl_in_reg <= hw_cyl ? host_wdata : cyl_in_reg;
            cyl_m_reg <= cyl_m_next;
            cyl_s_reg <= cyl_s_next;
        end
    end

    // the select lives in the input copy, so its clear steers reads to drive 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dh_in_reg <= `ITF_DATA_RESET;
            dh_m_reg <= `ITF_DATA_RESET;
            dh_s_reg <= `ITF_DATA_RESET;
        end else if (d3_to_d0) begin
            dh_in_reg <= `ITF_DATA_RESET;
            dh_m_reg <= `ITF_DATA_RESET;
            dh_s_reg <= `ITF_DATA_RESET;
        end else begin
            dh_in_reg <= dh_in_next;
            dh_m_reg <= dh_m_next;
            dh_s_reg <= dh_s_next;
        end
    end

    // strobe is a one-cycle pulse; the byte stands until the next command or a function reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= `ITF_DATA_RESET;
            cmd_stb_reg <= 1'b0;
        end else if (d3_to_d0) begin
            cmd_reg <= `ITF_DATA_RESET;
            cmd_stb_reg <= 1'b0;
        end else begin
            cmd_reg <= hw_cmd ? host_wdata : cmd_reg;
            cmd_stb_reg <= hw_cmd;
        end
    end

    // read data is registered, so a read answers in the following cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= `ITF_DATA_RESET;
        end else if (d3_to_d0) begin
            rdata_reg <= `ITF_DATA_RESET;
        end else begin
            rdata_reg <= rd_mux;
        end
    end

    // previous level starts low, the idle level of the control bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            srst_prev_reg <= 1'b0;
        end else begin
            srst_prev_reg <= soft_reset_bit;
        end
    end

    assign host_rdata = rdata_reg;
    assign irq_master = ctl.irq_master;
    assign command_out = cmd_reg;
    assign command_strobe = cmd_stb_reg;
    assign cyl_high_in = cyl_in_reg;
    assign drive_head_in = dh_in_reg;
    assign drive_select = dev_sel;
endmodule
`default_nettype wire

// File: sim/itf_bank_props.sv
// port assertions for the task-file bank
`timescale 1ns/1ps
`default_nettype none
module itf_bank_props (
    input wire logic clk, input wire logic nrst, input wire logic d3_to_d0,
    input wire logic host_cs, input wire logic host_wr, input wire logic host_rd,
    input wire logic [2:0] host_addr, input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata, input wire logic soft_reset_bit,
    input wire logic irq_event, input wire logic irq_master,
    input wire logic [7:0] command_out, input wire logic command_strobe,
    input wire logic [7:0] cyl_high_in, input wire logic [7:0] drive_head_in,
    input wire logic drive_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // function reset outranks host writes, so it is kept out of wr_ok
    wire wr_ok;
    assign wr_ok = host_cs && host_wr && !d3_to_d0;
    sequence cmd_wr_s; wr_ok && host_addr == 3'h7; endsequence
    sequence st_rd_s; host_cs && host_rd && host_addr == 3'h7 && !drive_select; endsequence
    ////////////////////////////////////////
    cyl_load_a: assert property (wr_ok && host_addr == 3'h5 |=>
        cyl_high_in == $past(host_wdata)) else $error("cyl input not loaded");
    dh_load_a: assert property (wr_ok && host_addr == 3'h6 && !$rose(soft_reset_bit)
        |=> drive_head_in == $past(host_wdata)) else $error("dh input not loaded");
    select_bit_a: assert property (drive_select == drive_head_in[4])
        else $error("select not bit 4");
    soft_clear_a: assert property ($rose(soft_reset_bit) |=> !drive_select)
        else $error("select kept on soft reset");
    cmd_load_a: assert property (cmd_wr_s |=> command_strobe &&
        command_out == $past(host_wdata)) else $error("command not taken");
    strobe_cause_a: assert property (command_strobe |->
        $past(host_cs && host_wr && host_addr == 3'h7)) else $error("stray strobe");
    irq_clear_a: assert property (st_rd_s ##0 !irq_event |=> !irq_master)
        else $error("irq kept after read");
    irq_set_a: assert property (irq_event && !d3_to_d0 |=> irq_master)
        else $error("irq not set");
    func_reset_a: assert property (d3_to_d0 |=> cyl_high_in == 8'h00 &&
        drive_head_in == 8'h00 && command_out == 8'h00) else $error("regs not reset");
    unmapped_rd_a: assert property (host_cs && host_rd && host_addr < 3'h5 |=>
        host_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind itf_bank itf_bank_props u_props (.clk(clk), .nrst(nrst), .d3_to_d0(d3_to_d0),
    .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .soft_reset_bit(soft_reset_bit),
    .irq_event(irq_event), .irq_master(irq_master), .command_out(command_out),
    .command_strobe(command_strobe), .cyl_high_in(cyl_high_in),
    .drive_head_in(drive_head_in), .drive_select(drive_select));
`default_nettype wire

// File: sim/test_itf_bank.sv
// self-checking bench for the task-file bank
`timescale 1ns/1ps
`default_nettype none
module test_itf_bank;
    logic clk = 1'b0, nrst = 1'b0, d3_to_d0 = 1'b0;
    logic host_cs = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
    logic soft_reset_bit = 1'b0, fw_we = 1'b0, irq_event = 1'b0;
    logic [2:0] host_addr = 3'h0, fw_sel = 3'h0;
    logic [7:0] host_wdata = 8'h00, fw_wdata = 8'h00;
    logic [7:0] host_rdata, command_out, cyl_high_in, drive_head_in;
    logic irq_master, command_strobe, drive_select;
    int err_count = 0, cmp_count = 0;
    itf_bank DUT (.clk(clk), .nrst(nrst), .d3_to_d0(d3_to_d0), .host_cs(host_cs),
        .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .soft_reset_bit(soft_reset_bit),
        .fw_we(fw_we), .fw_sel(fw_sel), .fw_wdata(fw_wdata), .irq_event(irq_event),
        .irq_master(irq_master), .command_out(command_out), .command_strobe(command_strobe),
        .cyl_high_in(cyl_high_in), .drive_head_in(drive_head_in), .drive_select(drive_select));
    always #20 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // one access per call; strobes drop at the next falling edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        {host_cs, host_wr, host_addr, host_wdata} = {2'b11, a, d};
        @(negedge clk);
        {host_cs, host_wr} = 2'b00;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
        @(negedge clk);
        {host_cs, host_rd, host_addr} = {2'b11, a};
        @(negedge clk);
        {host_cs, host_rd} = 2'b00;
        chk(n, host_rdata, e);
    endtask
    task automatic fw(input logic [2:0] s, input logic [7:0] d);
        @(negedge clk);
        {fw_we, fw_sel, fw_wdata} = {1'b1, s, d};
        @(negedge clk);
        fw_we = 1'b0;
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        rd(3'h5, 8'h00, "cyl rst");
        rd(3'h7, 8'h80, "status rst");
        fw(3'h4, 8'h59);
        rd(3'h7, 8'h59, "status fw");
        wr(3'h7, 8'hEC);
        chk("strobe", {7'h0, command_strobe}, 8'h01);
        chk("command", command_out, 8'hEC);
        rd(3'h7, 8'hD9, "busy cmd");
        @(negedge clk);
        irq_event = 1'b1;
        @(negedge clk);
        irq_event = 1'b0;
        chk("irq set", {7'h0, irq_master}, 8'h01);
        rd(3'h7, 8'hD9, "status ro");
        chk("irq clr", {7'h0, irq_master}, 8'h00);
        $display("test status done");
        wr(3'h5, 8'hA5);
        chk("cyl in", cyl_high_in, 8'hA5);
        fw(3'h1, 8'h3C);
        rd(3'h5, 8'hA5, "cyl master");
        wr(3'h6, 8'h1E);
        chk("select", {7'h0, drive_select}, 8'h01);
        rd(3'h5, 8'h3C, "cyl slave");
        rd(3'h6, 8'h1E, "dh copy");
        fw(3'h3, 8'h5A);
        fw(3'h2, 8'h77);
        rd(3'h6, 8'h5A, "dh slave");
        wr(3'h6, 8'h1F);
        rd(3'h6, 8'h1F, "dh host wr");
        $display("test steering done");
        fw(3'h4, 8'h00);
        wr(3'h7, 8'h30);
        rd(3'h7, 8'h00, "no busy slave");
        chk("command slave", command_out, 8'h30);
        @(negedge clk);
        soft_reset_bit = 1'b1;
        @(negedge clk);
        chk("dh soft", drive_head_in, 8'h0F);
        rd(3'h6, 8'h0F, "dh master");
        rd(3'h7, 8'h80, "busy soft");
        soft_reset_bit = 1'b0;
        @(negedge clk);
        {host_cs, host_wr, host_addr, host_wdata} = {2'b11, 3'h5, 8'h22};
        {fw_we, fw_sel, fw_wdata} = {1'b1, 3'h0, 8'h11};
        @(negedge clk);
        {host_cs, host_wr, fw_we} = 3'b000;
        rd(3'h5, 8'h22, "collision");
        $display("test soft reset done");
        wr(3'h2, 8'hFF);
        rd(3'h2, 8'h00, "unmapped");
        fw(3'h4, 8'h41);
        wr(3'h6, 8'hB3);
        @(negedge clk);
        d3_to_d0 = 1'b1;
        @(negedge clk);
        d3_to_d0 = 1'b0;
        chk("cyl d3", cyl_high_in, 8'h00);
        chk("dh d3", drive_head_in, 8'h00);
        chk("select d3", {7'h0, drive_select}, 8'h00);
        rd(3'h5, 8'h00, "cyl copy d3");
        rd(3'h7, 8'h80, "status d3");
        $display("test function reset done");
        end_sim();
    end
    // the sequence needs about 80 cycles; 600 leaves ample margin
    initial begin
        #(40 * 600);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
